// ### design/fbe_pkg.sv
/*
 * fbe_pkg: shared constants and carriers for the array bit-error reporting block.
 * Assumes an APB slave with 32-bit data; all offsets are byte addresses.
 */
package fbe_pkg;
	// register byte offsets
	localparam logic [11:0] FBE_OFF_CONFIG = 12'h000; // mem_ctrl_config_reg
	localparam logic [11:0] FBE_OFF_FLAG = 12'h004; // mem_ctrl_flag_reg
	localparam logic [11:0] FBE_OFF_RSTV = 12'h008; // reset_cause_vector
	localparam logic [11:0] FBE_OFF_NMIV = 12'h00C; // system_nmi_vector
	localparam logic [11:0] FBE_OFF_IRQ_MASK = 12'h010; // interrupt mask
	localparam logic [11:0] FBE_OFF_STATUS = 12'h014; // block state
	// config field positions
	localparam int FBE_B_RST_EN = 0; // uncorr_err_reset_en
	localparam int FBE_B_UIE = 1; // uncorr_err_irq_en
	localparam int FBE_B_CIE = 2; // corr_err_irq_en
	localparam int FBE_B_PWR = 3; // array_power_bit
	localparam int FBE_B_LPWR = 4; // array_lowpower_power_bit
	// flag field positions
	localparam int FBE_B_UFLG = 0; // uncorr_err_flag
	localparam int FBE_B_CFLG = 1; // corr_err_flag
	localparam logic [4:0] FBE_CONFIG_RST = 5'h18; // powers on, reporting off
	localparam logic [1:0] FBE_FLAG_RST = 2'h0;
	localparam logic [1:0] FBE_MASK_RST = 2'h0;
	// vector codes
	localparam logic [7:0] FBE_VEC_NONE = 8'h00;
	localparam logic [7:0] FBE_RSTV_UNCORR = 8'h1A; // reset cause: uncorrectable
	localparam logic [7:0] FBE_NMIV_UNCORR = 8'h02; // nmi source: uncorrectable
	localparam logic [7:0] FBE_NMIV_CORR = 8'h04; // nmi source: correctable
	// wake settling time and its cycle count at 125 MHz
	localparam int FBE_CLK_MHZ = 125;
	localparam int FBE_SETTLE_NS = 200;
	localparam int FBE_SETTLE_CYC = (FBE_SETTLE_NS * FBE_CLK_MHZ + 999) / 1000;
	// one array read result
	typedef struct packed {
		logic valid; // access read the array with valid data
		logic cache_hit; // served from cache, not from the array
		logic corr; // correctable error detected
		logic uncorr; // uncorrectable error detected
	} fbe_rd_t;
endpackage : fbe_pkg

// ### design/fbe_settle.sv
/*
 * fbe_settle: wake-up settling timer; holds busy for a fixed count after wake.
 * Assumes wake_pulse is a one-cycle pulse synchronous to pclk.
 */
`timescale 1ns/100ps
module fbe_settle import fbe_pkg::*; #(
	parameter int CYCLES = FBE_SETTLE_CYC
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic wake_pulse, // low-power exit event
	output logic busy // settling in progress
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_q; // cycles still to wait
	logic [CW-1:0] cnt_d;

	// reload on wake, otherwise count down and hold at zero
	always_comb begin
		cnt_d = cnt_q;
		if (wake_pulse) begin
			cnt_d = CW'(CYCLES);
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - CW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign busy = (cnt_q != '0);
endmodule : fbe_settle

// ### design/fbe_report.sv
/*
 * fbe_report: array bit-error reporting with APB registers.
 * Assumes array read results arrive one per cycle, synchronous to pclk,
 * and that reset and nmi consumers sample the one-cycle request pulses.
 */
`timescale 1ns/100ps
module fbe_report import fbe_pkg::*; #(
	parameter int SETTLE_CYCLES = FBE_SETTLE_CYC // wake settling window
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data, registered
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire fbe_rd_t rd, // array read result
	input wire logic lpm_active, // core is in low power mode 1..4
	output logic puc_req, // power-up-clear reset request pulse
	output logic nmi_req, // nmi request pulse
	output logic array_active, // array powered
	output logic irq // level interrupt, unmasked flag set
);
	logic [4:0] cfg_q, cfg_d; // mem_ctrl_config_reg
	logic [1:0] flg_q, flg_d; // mem_ctrl_flag_reg
	logic [1:0] msk_q, msk_d; // interrupt mask
	logic [7:0] rstv_q, rstv_d; // reset_cause_vector
	logic [7:0] nmiv_q, nmiv_d; // system_nmi_vector
	logic puc_q, puc_d;
	logic nmi_q, nmi_d;
	logic [31:0] rdata_q, rdata_d;
	logic lpm_q; // last lpm level, for wake edge
	logic settling; // wake window busy
	logic wake; // low power exit
	logic rd_ok; // usable array read
	logic ue, ce; // qualified error events
	logic wr_en, rd_en, hit;

	assign wake = lpm_q & ~lpm_active;

	fbe_settle #(.CYCLES(SETTLE_CYCLES)) u_settle (
		.pclk(pclk),
		.presetn(presetn),
		.wake_pulse(wake),
		.busy(settling)
	);

	// reads that hit the cache or come during settling report nothing;
	// the wake cycle itself is masked too, as the timer only loads at its edge
	assign rd_ok = rd.valid & ~rd.cache_hit & ~settling & ~wake & array_active;
	assign ue = rd_ok & rd.uncorr;
	assign ce = rd_ok & rd.corr & ~rd.uncorr;

	// apb decode: zero wait state, every access answered in its access cycle
	assign pready = 1'b1;
	always_comb begin
		hit = 1'b1;
		if (paddr == FBE_OFF_CONFIG) begin
			hit = 1'b1;
		end else if (paddr == FBE_OFF_FLAG) begin
			hit = 1'b1;
		end else if (paddr == FBE_OFF_RSTV) begin
			hit = 1'b1;
		end else if (paddr == FBE_OFF_NMIV) begin
			hit = 1'b1;
		end else if (paddr == FBE_OFF_IRQ_MASK) begin
			hit = 1'b1;
		end else if (paddr == FBE_OFF_STATUS) begin
			hit = 1'b1;
		end else begin
			hit = 1'b0;
		end
	end
	assign pslverr = psel & penable & ~hit;
	// writes land at the access edge, the one at which the master sees pready
	assign wr_en = psel & penable & pready & pwrite & hit;
	assign rd_en = psel & ~penable & ~pwrite & hit;

	// register next values; hardware set beats software clear
	always_comb begin
		cfg_d = cfg_q;
		msk_d = msk_q;
		flg_d = flg_q;
		rstv_d = rstv_q;
		nmiv_d = nmiv_q;
		if (wr_en && paddr == FBE_OFF_CONFIG) begin
			cfg_d = pwdata[4:0];
		end
		if (wr_en && paddr == FBE_OFF_IRQ_MASK) begin
			msk_d = pwdata[1:0];
		end
		// write one to clear, only software clears
		if (wr_en && paddr == FBE_OFF_FLAG) begin
			flg_d = flg_q & ~pwdata[1:0];
		end
		// reading a vector consumes it
		if (rd_en && paddr == FBE_OFF_RSTV) begin
			rstv_d = FBE_VEC_NONE;
		end
		if (rd_en && paddr == FBE_OFF_NMIV) begin
			nmiv_d = FBE_VEC_NONE;
		end
		if (ue) begin
			flg_d[FBE_B_UFLG] = 1'b1;
		end
		if (ce) begin
			flg_d[FBE_B_CFLG] = 1'b1;
		end
		if (ue && cfg_q[FBE_B_RST_EN]) begin
			rstv_d = FBE_RSTV_UNCORR;
		end
		// uncorrectable source outranks correctable
		if (ue && cfg_q[FBE_B_UIE]) begin
			nmiv_d = FBE_NMIV_UNCORR;
		end else if (ce && cfg_q[FBE_B_CIE]) begin
			nmiv_d = FBE_NMIV_CORR;
		end
	end

	// request pulses
	always_comb begin
		puc_d = ue & cfg_q[FBE_B_RST_EN];
		nmi_d = (ue & cfg_q[FBE_B_UIE]) | (ce & cfg_q[FBE_B_CIE]);
	end

	// read data mux, captured in setup so it is stable in access
	always_comb begin
		rdata_d = rdata_q;
		if (rd_en) begin
			if (paddr == FBE_OFF_CONFIG) begin
				rdata_d = {27'h0, cfg_q};
			end else if (paddr == FBE_OFF_FLAG) begin
				rdata_d = {30'h0, flg_q};
			end else if (paddr == FBE_OFF_RSTV) begin
				rdata_d = {24'h0, rstv_q};
			end else if (paddr == FBE_OFF_NMIV) begin
				rdata_d = {24'h0, nmiv_q};
			end else if (paddr == FBE_OFF_IRQ_MASK) begin
				rdata_d = {30'h0, msk_q};
			end else begin
				rdata_d = {29'h0, settling, lpm_active, array_active};
			end
		end else if (psel & ~penable) begin
			rdata_d = 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= FBE_CONFIG_RST;
			flg_q <= FBE_FLAG_RST;
			msk_q <= FBE_MASK_RST;
			rstv_q <= FBE_VEC_NONE;
			nmiv_q <= FBE_VEC_NONE;
			puc_q <= 1'b0;
			nmi_q <= 1'b0;
			rdata_q <= 32'h0;
			lpm_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			flg_q <= flg_d;
			msk_q <= msk_d;
			rstv_q <= rstv_d;
			nmiv_q <= nmiv_d;
			puc_q <= puc_d;
			nmi_q <= nmi_d;
			rdata_q <= rdata_d;
			lpm_q <= lpm_active;
		end
	end

	assign prdata = rdata_q;
	assign puc_req = puc_q;
	assign nmi_req = nmi_q;
	// array inactive only when both power bits are clear
	assign array_active = cfg_q[FBE_B_PWR] | cfg_q[FBE_B_LPWR];
	assign irq = |(flg_q & msk_q);

	// assertions
	property p_puc;
		@(posedge pclk) disable iff (!presetn)
		(ue && cfg_q[FBE_B_RST_EN]) |=> puc_req && rstv_q == FBE_RSTV_UNCORR;
	endproperty
	a_puc: assert property (p_puc) else $error("reset not raised on uncorrectable error");

	property p_nmi_u;
		@(posedge pclk) disable iff (!presetn)
		(ue && cfg_q[FBE_B_UIE]) |=> nmi_req && nmiv_q == FBE_NMIV_UNCORR;
	endproperty
	a_nmi_u: assert property (p_nmi_u) else $error("nmi missing for uncorrectable");

	property p_nmi_c;
		@(posedge pclk) disable iff (!presetn)
		(ce && cfg_q[FBE_B_CIE] && !(ue && cfg_q[FBE_B_UIE])) |=> nmi_req && nmiv_q == FBE_NMIV_CORR;
	endproperty
	a_nmi_c: assert property (p_nmi_c) else $error("nmi missing for correctable");

	property p_sticky;
		@(posedge pclk) disable iff (!presetn)
		(flg_q[FBE_B_CFLG] && !(wr_en && paddr == FBE_OFF_FLAG)) |=> flg_q[FBE_B_CFLG];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

	property p_uflag;
		@(posedge pclk) disable iff (!presetn)
		ue |=> flg_q[FBE_B_UFLG];
	endproperty
	a_uflag: assert property (p_uflag) else $error("uncorrectable flag not set");

	// holding is checked apart, so a clear right after the set is legal
	property p_usticky;
		@(posedge pclk) disable iff (!presetn)
		(flg_q[FBE_B_UFLG] && !(wr_en && paddr == FBE_OFF_FLAG)) |=> flg_q[FBE_B_UFLG];
	endproperty
	a_usticky: assert property (p_usticky) else $error("uncorrectable flag dropped without clear");

	property p_power;
		@(posedge pclk) disable iff (!presetn)
		!array_active |-> !puc_d && !nmi_d;
	endproperty
	a_power: assert property (p_power) else $error("report while array inactive");

	property p_settle;
		@(posedge pclk) disable iff (!presetn)
		wake |=> (!puc_req && !nmi_req) [*2];
	endproperty
	a_settle: assert property (p_settle) else $error("report during wake settling");

	property p_quiet;
		@(posedge pclk) disable iff (!presetn)
		(!rd.valid || rd.cache_hit) |=> !puc_req && !nmi_req;
	endproperty
	a_quiet: assert property (p_quiet) else $error("report without array read");

	property p_c_puc;
		@(posedge pclk) disable iff (!presetn) puc_req;
	endproperty
	c_puc: cover property (p_c_puc);
	property p_c_nmi;
		@(posedge pclk) disable iff (!presetn) nmi_req && nmiv_q == FBE_NMIV_CORR;
	endproperty
	c_nmi: cover property (p_c_nmi);
	property p_c_wake;
		@(posedge pclk) disable iff (!presetn) wake ##1 settling;
	endproperty
	c_wake: cover property (p_c_wake);
endmodule : fbe_report

// ### dv/fbe_array_model.sv
/* fbe_array_model: array read source feeding the reporting block.
   Assumes the bench drives cmd and go right after a rising edge. */
`timescale 1ns/100ps
module fbe_array_model import fbe_pkg::*; (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire fbe_rd_t cmd, // result to present
	input wire logic go, // present cmd next cycle
	output fbe_rd_t rd // result to the block
);
	// idle cycles flip the error bits, so stale flags never look clean
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd <= '0;
		end else if (go) begin
			rd <= cmd;
		end else begin
			rd <= {1'b0, ~rd.cache_hit, ~rd.corr, ~rd.uncorr}; // invalid, noisy
		end
	end
endmodule : fbe_array_model

// ### dv/tb_top.sv
/* tb_top: self-checking bench for the bit-error reporting block.
   Assumes zero-wait apb and one-cycle report pulses. */
`timescale 1ns/100ps
module tb_top import fbe_pkg::*;;
	logic pclk = 1'b0; // system clock
	logic presetn = 1'b0; // reset, active low
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb control
	logic [11:0] paddr = '0; // apb address
	logic [31:0] pwdata = '0, prdata, q; // apb data
	logic pready, pslverr, puc_req, nmi_req, array_active, irq, err; // outputs
	logic lpm_active = 1'b0, go = 1'b0; // sleep and read strobe
	fbe_rd_t cmd = '0, rd; // array read result
	int fails = 0, compares = 0, cyc = 0; // counters

	// 8 ns period
	always #4 pclk = ~pclk;

	fbe_report #(.SETTLE_CYCLES(3)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rd(rd), .lpm_active(lpm_active), .puc_req(puc_req), .nmi_req(nmi_req), .array_active(array_active),
		.irq(irq));
	fbe_array_model mdl_u (.pclk(pclk), .presetn(presetn), .cmd(cmd), .go(go), .rd(rd));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer, entered right after a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for the answer; pready high ends this wait, the hang guard catches a stall
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rdc

	// one array read; e is the expected {puc_req, nmi_req}, one cycle wide
	task ev(input fbe_rd_t r, input logic [1:0] e);
		cmd <= r;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		@(negedge pclk);
		chk({puc_req, nmi_req}, e);
		@(negedge pclk);
		chk({puc_req, nmi_req}, 2'b00);
		@(posedge pclk);
	endtask : ev

	task stop_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	// hang guard, runs need about 140 cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			stop_test;
		end
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(FBE_OFF_CONFIG, 32'h18);
		rdc(FBE_OFF_FLAG, 32'h0);
		rdc(FBE_OFF_RSTV, 32'h0);
		rdc(FBE_OFF_STATUS, 32'h1);
		rdc(12'h020, 32'h0);
		chk(err, 1'b1);
		$display("test reset done");
		wr(FBE_OFF_CONFIG, 32'h19);
		ev(4'h9, 2'b10);
		rdc(FBE_OFF_RSTV, {24'h0, FBE_RSTV_UNCORR});
		rdc(FBE_OFF_FLAG, 32'h1);
		chk(irq, 1'b0);
		wr(FBE_OFF_IRQ_MASK, 32'h3);
		chk(irq, 1'b1);
		wr(FBE_OFF_FLAG, 32'h1);
		rdc(FBE_OFF_FLAG, 32'h0);
		chk(irq, 1'b0);
		$display("test uncorrectable reset done");
		wr(FBE_OFF_CONFIG, 32'h1A);
		ev(4'h9, 2'b01);
		rdc(FBE_OFF_NMIV, {24'h0, FBE_NMIV_UNCORR});
		rdc(FBE_OFF_NMIV, 32'h0);
		ev(4'hD, 2'b00);
		ev(4'h1, 2'b00);
		wr(FBE_OFF_CONFIG, 32'h1C);
		ev(4'hA, 2'b01);
		rdc(FBE_OFF_NMIV, {24'h0, FBE_NMIV_CORR});
		// uncorrectable flag from the read under 0x1A is still set
		rdc(FBE_OFF_FLAG, 32'h3);
		$display("test nmi done");
		wr(FBE_OFF_FLAG, 32'h3);
		wr(FBE_OFF_CONFIG, 32'h18);
		lpm_active <= 1'b1;
		repeat (5) @(posedge pclk);
		lpm_active <= 1'b0;
		@(posedge pclk);
		ev(4'h9, 2'b00);
		rdc(FBE_OFF_FLAG, 32'h0);
		repeat (8) @(posedge pclk);
		ev(4'h8, 2'b00);
		wr(FBE_OFF_CONFIG, 32'h19);
		ev(4'h9, 2'b10);
		$display("test wake done");
		wr(FBE_OFF_FLAG, 32'h3);
		wr(FBE_OFF_CONFIG, 32'h09);
		chk(array_active, 1'b1);
		wr(FBE_OFF_CONFIG, 32'h01);
		chk(array_active, 1'b0);
		ev(4'h9, 2'b00);
		rdc(FBE_OFF_FLAG, 32'h0);
		wr(FBE_OFF_CONFIG, 32'h18);
		chk(array_active, 1'b1);
		$display("test power done");
		stop_test;
	end
endmodule : tb_top
